// ==== core/fdc_fast_detect.sv ====
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module fdc_fast_detect
	import fdc_pkg::*;
#(
	parameter int SAMPLE_W = 12,
	parameter int CAL_LOG2 = 10
)
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [SAMPLE_W-1:0] sample,
	input  wire logic [ADDR_W-1:0]   regAddr,
	input  wire logic [DATA_W-1:0]   regWdata,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	output logic      [DATA_W-1:0]   regRdata,
	output logic                     overrangeFlag,
	output logic                     coefUpdate,
	output logic                     irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int ACC_W = THR_W + CAL_LOG2;
	localparam logic [CAL_LOG2-1:0] CAL_LAST = '1;

	typedef struct packed {
		logic [THR_W-1:0]    upThr;
		logic [THR_W-1:0]    lowThr;
		logic [THR_W-1:0]    dwell;
		logic [THR_W-1:0]    calThr;
		logic [DATA_W-1:0]   stage;
		logic                gateEn;
		logic                flag;
		logic [THR_W:0]      dwellCnt;
		logic [ACC_W-1:0]    acc;
		logic [CAL_LOG2-1:0] calCnt;
		logic                calPass;
		logic                coefUpd;
		logic [IRQ_N-1:0]    irqStat;
		logic [IRQ_N-1:0]    irqEn;
		logic                irqOut;
		logic [DATA_W-1:0]   rdata;
	} fdc_state_s;

	fdc_state_s st;
	fdc_state_s next_st;

	logic [THR_W-1:0]  mag;
	logic [ACC_W-1:0]  accSum;
	logic [THR_W-1:0]  average;
	logic [IRQ_N-1:0]  events;
	logic [IRQ_N-1:0]  clearMask;
	logic              passNow;

	// ----------------------------------------------------------------
	// Sample capture
	// ----------------------------------------------------------------
	fdc_magnitude #(
		.SAMPLE_W (SAMPLE_W)
	) u_mag (
		.clk       (clk),
		.reset     (reset),
		.sample    (sample),
		.magnitude (mag)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st   = st;
		events    = '0;
		clearMask = '0;
		accSum    = st.acc + ACC_W'(mag); // R5
		average   = THR_W'(accSum >> CAL_LOG2);
		// Average magnitude and threshold share the 0..0x4000 scale
		passNow   = average > st.calThr; // R9

		// Fast detect with hysteresis
		next_st.coefUpd = 1'b0;
		if (mag > st.upThr)
		begin
			next_st.flag     = 1'b1; // R2
			next_st.dwellCnt = '0;
			if (!st.flag)
				events[IRQ_FLAG_SET] = 1'b1;
		end
		else if (st.flag)
		begin
			if (mag < st.lowThr)
			begin
				// Counter is one bit wider so a dwell of 0xFFFF can still expire
				if (st.dwellCnt > {1'b0, st.dwell})
				begin
					next_st.flag         = 1'b0; // R3
					next_st.dwellCnt     = '0;
					events[IRQ_FLAG_CLR] = 1'b1;
				end
				else
				begin
					next_st.dwellCnt = st.dwellCnt + 1'b1; // R3
				end
			end
			else
			begin
				next_st.dwellCnt = '0; // R4
			end
		end
		else
		begin
			next_st.dwellCnt = '0;
		end

		// Calibration gate over a fixed block of samples
		if (st.calCnt == CAL_LAST)
		begin
			next_st.acc     = '0;
			next_st.calCnt  = '0;
			next_st.calPass = passNow; // R6
			// With the gate off every block updates; gate on needs a strict pass
			if (passNow || !st.gateEn)
			begin
				next_st.coefUpd        = 1'b1; // R7
				events[IRQ_CAL_UPDATE] = 1'b1;
			end
			else
			begin
				events[IRQ_CAL_SKIP] = 1'b1; // R7
			end
		end
		else
		begin
			next_st.acc    = accSum; // R5
			next_st.calCnt = st.calCnt + 1'b1;
		end

		// Register writes
		if (regWrite)
		begin
			case (regAddr)
				OFS_UPPER_LO,
				OFS_LOWER_LO,
				OFS_DWELL_LO,
				OFS_CALTH_LO: next_st.stage = regWdata; // R8
				OFS_UPPER_HI: next_st.upThr = {regWdata, st.stage}; // R8
				OFS_LOWER_HI: next_st.lowThr = {regWdata, st.stage}; // R8
				OFS_DWELL_HI: next_st.dwell = {regWdata, st.stage}; // R8
				OFS_CALTH_HI: next_st.calThr = {regWdata, st.stage}; // R8
				OFS_CONTROL:  next_st.gateEn = regWdata[CTRL_GATE_BIT];
				OFS_IRQ_EN:   next_st.irqEn = regWdata[IRQ_N-1:0];
				OFS_IRQ_CLR:  clearMask = regWdata[IRQ_N-1:0];
				default:      next_st.stage = st.stage;
			endcase
		end

		// A new event wins over a clear in the same cycle
		next_st.irqStat = (st.irqStat & ~clearMask) | events;
		next_st.irqOut  = |(next_st.irqStat & next_st.irqEn);

		// Read data stands only in the cycle after the strobe
		next_st.rdata = '0;
		if (regRead)
		begin
			case (regAddr)
				OFS_UPPER_LO: next_st.rdata = st.upThr[7:0];
				OFS_UPPER_HI: next_st.rdata = st.upThr[15:8];
				OFS_LOWER_LO: next_st.rdata = st.lowThr[7:0];
				OFS_LOWER_HI: next_st.rdata = st.lowThr[15:8];
				OFS_DWELL_LO: next_st.rdata = st.dwell[7:0];
				OFS_DWELL_HI: next_st.rdata = st.dwell[15:8];
				OFS_CALTH_LO: next_st.rdata = st.calThr[7:0];
				OFS_CALTH_HI: next_st.rdata = st.calThr[15:8];
				OFS_CONTROL:  next_st.rdata[CTRL_GATE_BIT] = st.gateEn;
				OFS_STATUS:
				begin
					next_st.rdata[STAT_FLAG_BIT] = st.flag;
					next_st.rdata[STAT_PASS_BIT] = st.calPass;
				end
				OFS_IRQ_STAT: next_st.rdata[IRQ_N-1:0] = st.irqStat;
				OFS_IRQ_EN:   next_st.rdata[IRQ_N-1:0] = st.irqEn;
				default:      next_st.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			st        <= '0;
			st.upThr  <= RST_UPPER;
			st.lowThr <= RST_LOWER;
			st.dwell  <= RST_DWELL;
			st.calThr <= RST_CALTH;
			st.gateEn <= RST_GATE; // R10
			st.irqEn  <= RST_IRQ_EN;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign overrangeFlag = st.flag; // R11
	assign coefUpdate    = st.coefUpd;
	assign irq           = st.irqOut;
	assign regRdata      = st.rdata;

endmodule

// ==== core/fdc_pkg.sv ====
// Notes on behaviour
// R1: Each new sample is captured on the rising clock edge and all magnitude work uses it.
// R2: The overrange flag rises as soon as a sample magnitude is above the upper threshold.
// R3: The flag falls only after the magnitude stays below the lower threshold past the dwell.
// R4: While the flag is up, a magnitude at or above the lower threshold restarts the dwell count.
// R5: Every sample magnitude is added into an accumulator that forms the average magnitude.
// R6: After the fixed number of samples the average is compared with the calibration threshold.
// R7: Coefficients update only when the average is strictly above the threshold; the code updates after every block while the gate bit is clear.
// R8: Each threshold is a 16-bit value written one byte per transfer and assembled here.
// R9: The calibration threshold is an average magnitude from 0 to 0x4000, which is full scale.
// R10: Threshold gating of calibration updates is active straight out of reset.
// R11: The overrange flag drives its own dedicated output pin.
package fdc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int THR_W  = 16;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_UPPER_LO = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_UPPER_HI = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_LOWER_LO = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_LOWER_HI = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_DWELL_LO = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_DWELL_HI = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_CALTH_LO = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_CALTH_HI = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_CONTROL  = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 4'hB;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 4'hC;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_GATE_BIT   = 0;
	localparam int STAT_FLAG_BIT   = 0;
	localparam int STAT_PASS_BIT   = 1;
	localparam int IRQ_N           = 4;
	localparam int IRQ_FLAG_SET    = 0;
	localparam int IRQ_FLAG_CLR    = 1;
	localparam int IRQ_CAL_UPDATE  = 2;
	localparam int IRQ_CAL_SKIP    = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [THR_W-1:0]  RST_UPPER  = 16'h3000;
	localparam logic [THR_W-1:0]  RST_LOWER  = 16'h2000;
	localparam logic [THR_W-1:0]  RST_DWELL  = 16'h0010;
	localparam logic [THR_W-1:0]  RST_CALTH  = 16'h0800;
	localparam logic              RST_GATE   = 1'b1;
	localparam logic [IRQ_N-1:0]  RST_IRQ_EN = 4'h0;

	// Full scale of the magnitude scale shared by all thresholds
	localparam logic [THR_W-1:0]  MAG_FULL_SCALE = 16'h4000;

endpackage

// ==== core/fdc_magnitude.sv ====
`timescale 1ns/10ps
module fdc_magnitude
	import fdc_pkg::*;
#(
	parameter int SAMPLE_W = 12
)
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [SAMPLE_W-1:0] sample,
	output logic      [THR_W-1:0]    magnitude
);

	// ----------------------------------------------------------------
	// Absolute value scaled so that full scale equals 0x4000
	// ----------------------------------------------------------------
	localparam int SHIFT = 15 - SAMPLE_W;

	typedef struct packed {
		logic [THR_W-1:0] mag;
	} fdc_mag_s;

	fdc_mag_s st;
	fdc_mag_s next_st;
	logic [SAMPLE_W:0] absVal;

	always_comb
	begin
		next_st = st;
		// Sign extension first so the most negative code does not wrap
		if (sample[SAMPLE_W-1])
			absVal = (SAMPLE_W+1)'(-$signed({sample[SAMPLE_W-1], sample}));
		else
			absVal = {1'b0, sample};
		next_st.mag = THR_W'(absVal) << SHIFT; // R1
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st; // R1
	end

	assign magnitude = st.mag;

endmodule

// ==== dv/fdc_fast_detect_props.sv ====
`timescale 1ns/10ps
module fdc_fast_detect_props
	import fdc_pkg::*;
#(
	parameter int SAMPLE_W = 12,
	parameter int CAL_LOG2 = 10
)
(
	input wire logic                clk,
	input wire logic                reset,
	input wire logic [SAMPLE_W-1:0] sample,
	input wire logic [ADDR_W-1:0]   regAddr,
	input wire logic [DATA_W-1:0]   regWdata,
	input wire logic                regWrite,
	input wire logic                regRead,
	input wire logic [DATA_W-1:0]   regRdata,
	input wire logic                overrangeFlag,
	input wire logic                coefUpdate,
	input wire logic                irq
);
	logic [THR_W-1:0]    mag;
	logic [DATA_W-1:0]   stage;
	logic [THR_W-1:0]    upper;
	logic [THR_W-1:0]    lower;
	logic [THR_W-1:0]    dwell;
	logic [16:0]         belowRun;
	logic [CAL_LOG2-1:0] gap;
	logic                seen;
	// ----------------------------------------
	// Shadow state
	// ----------------------------------------
	always_comb mag = THR_W'(sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample) << (THR_W-SAMPLE_W-1);
	// Thresholds mirrored from bus writes; stimulus must not move them near a flag event
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stage <= 8'h00;
			upper <= RST_UPPER;
			lower <= RST_LOWER;
			dwell <= RST_DWELL;
			belowRun <= 17'h0;
			gap <= '0;
			seen <= 1'b0;
		end
		else
		begin
			if (regWrite && !regAddr[0] && regAddr < OFS_CONTROL)
				stage <= regWdata;
			if (regWrite && regAddr == OFS_UPPER_HI)
				upper <= {regWdata, stage};
			if (regWrite && regAddr == OFS_LOWER_HI)
				lower <= {regWdata, stage};
			if (regWrite && regAddr == OFS_DWELL_HI)
				dwell <= {regWdata, stage};
			belowRun <= (mag < lower) ? belowRun + 17'h1 : 17'h0;
			gap <= coefUpdate ? '0 : gap + 1'b1;
			seen <= seen | coefUpdate;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_read_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
		else $error("read data outside slot");
	a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) > OFS_IRQ_CLR |-> regRdata == 8'h00)
		else $error("unmapped read not zero");
	a_upper_readback: assert property ($past(regRead) && $past(regAddr) == OFS_UPPER_HI
		|-> regRdata == $past(upper) >> 8)
		else $error("upper threshold readback wrong");
	a_status_flag: assert property ($past(regRead) && $past(regAddr) == OFS_STATUS
		|-> regRdata[STAT_FLAG_BIT] == $past(overrangeFlag))
		else $error("status flag bit wrong");
	a_flag_rise: assert property (mag > upper |-> ##2 overrangeFlag)
		else $error("flag missed upper crossing");
	a_flag_fall: assert property ($fell(overrangeFlag) |-> $past(belowRun) >= dwell + 17'h2)
		else $error("flag cleared before dwell");
	a_dwell_restart: assert property (mag >= lower ##2 overrangeFlag |-> ##1 overrangeFlag[*2])
		else $error("dwell not restarted");
	a_pulse_single: assert property (coefUpdate |=> !coefUpdate)
		else $error("update pulse too long");
	a_block_spacing: assert property (coefUpdate && seen |-> gap == '1)
		else $error("update off block boundary");
endmodule
bind fdc_fast_detect fdc_fast_detect_props #(.SAMPLE_W(SAMPLE_W), .CAL_LOG2(CAL_LOG2)) u_fdc_fast_detect_props
	(.clk, .reset, .sample, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
	.overrangeFlag, .coefUpdate, .irq);

// ==== dv/fdc_vga_model.sv ====
`timescale 1ns/10ps
module fdc_vga_model
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       overrangeFlag,
	output logic      [3:0] gainSteps
);
	logic flagSeen;
	// Gain only steps down, never back, so a chattering flag shows as extra steps
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flagSeen <= 1'b0;
			gainSteps <= 4'h0;
		end
		else
		begin
			flagSeen <= overrangeFlag;
			if (overrangeFlag && !flagSeen)
				gainSteps <= gainSteps + 4'h1;
		end
	end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errCount++; \
	$display("mismatch %0t got %0h exp %0h", $time, a, e); end end
module tb
	import fdc_pkg::*;
;
	typedef struct packed {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} fdc_row_s;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic [11:0]       sample = 12'h000;
	logic [ADDR_W-1:0] regAddr = 4'h0;
	logic [DATA_W-1:0] regWdata = 8'h00;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	logic [DATA_W-1:0] regRdata;
	logic              overrangeFlag;
	logic              coefUpdate;
	logic              irq;
	logic [3:0]        gainSteps;
	logic [DATA_W-1:0] rdVal;
	int                errCount = 0;
	int                checksDone = 0;
	int                n;
	fdc_row_s          rows [14] = '{'{4'h0, 8'h00}, '{4'h1, 8'h30}, '{4'h2, 8'h00}, '{4'h3, 8'h20},
		'{4'h4, 8'h10}, '{4'h5, 8'h00}, '{4'h6, 8'h00}, '{4'h7, 8'h08}, '{4'h8, 8'h01},
		'{4'h9, 8'h00}, '{4'hA, 8'h08}, '{4'hB, 8'h00}, '{4'hC, 8'h00}, '{4'hD, 8'h00}};
	always #12.5 clk = ~clk;
	fdc_fast_detect #(.CAL_LOG2(3)) u_fdc_fast_detect (.clk, .reset, .sample, .regAddr, .regWdata,
		.regWrite, .regRead, .regRdata, .overrangeFlag, .coefUpdate, .irq);
	fdc_vga_model u_fdc_vga_model (.clk, .reset, .overrangeFlag, .gainSteps);
	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	// Low byte first: the high byte commits both halves at once
	task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(4'(a + 1), v[15:8]);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rdVal = regRdata;
	endtask
	task automatic feed(input logic [11:0] s, input int k);
		repeat (k) @(posedge clk) sample <= s;
		#1;
	endtask
	// Skip two blocks of settling, then count pulses over four blocks
	task automatic pulses(output int c);
		repeat (16) @(posedge clk);
		c = 0;
		repeat (32) @(posedge clk) #1 c += int'(coefUpdate === 1'b1);
	endtask
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			rd(rows[i].a);
			`CHK(rdVal, rows[i].d)
		end
		$display("reset values done");
		wr16(OFS_UPPER_LO, 16'h2000);
		wr16(OFS_LOWER_LO, 16'h1000);
		wr16(OFS_DWELL_LO, 16'h0002);
		rd(OFS_UPPER_HI);
		`CHK(rdVal, 8'h20)
		feed(12'h400, 6);
		`CHK(overrangeFlag, 1'b0)
		feed(12'hBFF, 1);
		feed(12'h1FF, 3);
		feed(12'h200, 3);
		`CHK(overrangeFlag, 1'b1)
		feed(12'h1FF, 4);
		`CHK(overrangeFlag, 1'b1)
		feed(12'h200, 3);
		`CHK(overrangeFlag, 1'b0)
		`CHK(gainSteps, 4'h1)
		$display("fast detect done");
		feed(12'h000, 1);
		`CHK(irq, 1'b0)
		rd(OFS_IRQ_STAT);
		`CHK(rdVal[1:0], 2'b11)
		wr(OFS_IRQ_EN, 8'h03);
		feed(12'h000, 2);
		`CHK(irq, 1'b1)
		wr(OFS_IRQ_CLR, 8'h03);
		feed(12'h000, 2);
		`CHK(irq, 1'b0)
		$display("interrupts done");
		pulses(n);
		`CHK(n, 0)
		feed(12'h100, 1);
		pulses(n);
		`CHK(n, 0)
		wr(OFS_IRQ_CLR, 8'h04);
		rd(OFS_IRQ_STAT);
		`CHK(rdVal[3:2], 2'b10)
		feed(12'h101, 1);
		pulses(n);
		`CHK(n, 4)
		rd(OFS_IRQ_STAT);
		`CHK(rdVal[IRQ_CAL_UPDATE], 1'b1)
		rd(OFS_STATUS);
		`CHK(rdVal[STAT_PASS_BIT], 1'b1)
		wr(OFS_CONTROL, 8'h00);
		feed(12'h000, 1);
		pulses(n);
		`CHK(n, 4)
		wr(OFS_CONTROL, 8'h01);
		wr16(OFS_CALTH_LO, MAG_FULL_SCALE);
		feed(12'h800, 1);
		pulses(n);
		`CHK(n, 0)
		wr16(OFS_CALTH_LO, MAG_FULL_SCALE - 16'h1);
		pulses(n);
		`CHK(n, 4)
		feed(12'h000, 1);
		@(posedge clk) reset <= 1'b1;
		@(posedge clk) reset <= 1'b0;
		rd(OFS_CALTH_HI);
		`CHK(rdVal, 8'h08)
		$display("calibration done");
		closeOut();
	end
	initial
	begin
		#100000;
		errCount++;
		closeOut();
	end
endmodule
